// *** core_stack_register_access.v ***
// core register access: return-stack index, page bits, configuration,
// step-math scratch and pseudo registers, square-root scratch, program counter
// assumes the sequencer gives one access per cycle with the parameter stack top
// on PSTACK_TOP_IN and applies the push, pop, call and return pulses it gets back
// assumes the page inputs hold the page of the executing instruction
// return stack limits are watched elsewhere; the memory pointer wraps
`timescale 1ns/10ps
`default_nettype none
`include "core_regs_map.vh"

module core_stack_register_access (
  // clock and reset
  input  wire        CLK_IN,
  input  wire        RESET_IN,
  // register access from the sequencer
  input  wire        ACCESS_VALID_IN,
  input  wire        ACCESS_WRITE_IN,
  input  wire [4:0]  ACCESS_ADDR_IN,
  input  wire        ACCESS_RETURN_IN,
  input  wire [15:0] PSTACK_TOP_IN,
  // processor state inputs
  input  wire [3:0]  CODE_PAGE_IN,
  input  wire        DATA_PAGE_SELECT_IN,
  input  wire [15:0] NEXT_PC_IN,
  input  wire        INTERRUPT_PENDING_IN,
  // parameter stack requests
  output reg         PSTACK_PUSH_OUT,
  output reg         PSTACK_POP_OUT,
  output reg  [15:0] PSTACK_DATA_OUT,
  // program flow requests
  output reg         CALL_OUT,
  output reg  [15:0] CALL_ADDR_OUT,
  output reg         RETURN_OUT,
  output reg  [20:0] RETURN_ADDR_OUT,
  // streamed instruction count
  output reg         STREAM_LOAD_OUT,
  output wire [15:0] STREAM_COUNT_OUT,
  // configuration outputs
  output wire        BOOT_SELECT_OUT,
  output wire        BYTE_ORDER_OUT,
  output wire        INTERRUPTS_DISABLED_OUT
);

  // return stack top entry
  reg  [15:0] index_q;
  reg  [15:0] index_d;
  reg  [4:0]  page_bits_q;
  reg  [4:0]  page_bits_d;
  // configuration bits
  reg         disable_q;
  reg         disable_d;
  reg         boot_q;
  reg         boot_d;
  reg         byte_order_q;
  reg         byte_order_d;
  // scratch registers
  reg  [15:0] step_scratch_q;
  reg  [15:0] step_scratch_d;
  reg  [15:0] root_scratch_q;
  reg  [15:0] root_scratch_d;
  // next values of the output pulses and data
  reg         ppush_d;
  reg         ppop_d;
  reg  [15:0] pdata_d;
  reg         call_d;
  reg  [15:0] call_addr_d;
  reg         ret_d;
  reg  [20:0] ret_addr_d;
  reg         stream_d;
  // return stack memory requests
  reg         rs_push;
  reg         rs_pop;
  reg  [20:0] rs_wdata;

  // decoded access and the assembled top entry
  wire [20:0] rs_next;
  wire [20:0] top_entry;
  wire [4:0]  cur_page;
  wire [15:0] config_word;
  wire        rd;
  wire        wr;
  wire        in_ret;

  assign top_entry = {page_bits_q, index_q};
  assign cur_page  = {DATA_PAGE_SELECT_IN, CODE_PAGE_IN};
  assign rd        = ACCESS_VALID_IN && !ACCESS_WRITE_IN;
  assign wr        = ACCESS_VALID_IN && ACCESS_WRITE_IN;
  assign in_ret    = ACCESS_RETURN_IN;

  // configuration read image: bit 4 and reserved bits read as zero
  assign config_word = {INTERRUPT_PENDING_IN,
                        disable_q,
                        9'h000,
                        1'b0,
                        boot_q,
                        byte_order_q,
                        2'h0};

  // configuration outputs and repeat count straight from the registers
  assign BOOT_SELECT_OUT         = boot_q;
  assign BYTE_ORDER_OUT          = byte_order_q;
  assign INTERRUPTS_DISABLED_OUT = disable_q;
  assign STREAM_COUNT_OUT        = index_q;

  // access decode: next register values and requests
  always @* begin
    index_d        = index_q;
    page_bits_d    = page_bits_q;
    disable_d      = disable_q;
    boot_d         = boot_q;
    byte_order_d   = byte_order_q;
    step_scratch_d = step_scratch_q;
    root_scratch_d = root_scratch_q;
    ppush_d        = 1'b0;
    ppop_d         = 1'b0;
    pdata_d        = PSTACK_DATA_OUT;
    call_d         = 1'b0;
    call_addr_d    = CALL_ADDR_OUT;
    ret_d          = 1'b0;
    ret_addr_d     = RETURN_ADDR_OUT;
    stream_d       = 1'b0;
    rs_push        = 1'b0;
    rs_pop         = 1'b0;
    rs_wdata       = top_entry;
    // reads push onto the parameter stack
    if (rd) begin
      case (ACCESS_ADDR_IN)
        // direct index, a return pops after the push
        `ADDR_INDEX_DIRECT: begin
          ppush_d = 1'b1;
          pdata_d = index_q;
          if (in_ret) begin
            ret_d      = 1'b1;
            ret_addr_d = top_entry;
            index_d    = rs_next[15:0];
            page_bits_d = rs_next[20:16];
            rs_pop     = 1'b1;
          end
        end

        // push/pop index, the return stack pops once
        `ADDR_INDEX_PUSHPOP: begin
          ppush_d     = 1'b1;
          pdata_d     = index_q;
          index_d     = rs_next[15:0];
          page_bits_d = rs_next[20:16];
          rs_pop      = 1'b1;
          if (in_ret) begin
            ret_d      = 1'b1;
            ret_addr_d = top_entry;
          end
        end

        // loop count image is the index doubled
        `ADDR_INDEX_LOOP: begin
          ppush_d = 1'b1;
          pdata_d = {index_q[14:0], 1'b0};
          if (in_ret) begin
            ret_d       = 1'b1;
            ret_addr_d  = top_entry;
            index_d     = rs_next[15:0];
            page_bits_d = rs_next[20:16];
            rs_pop      = 1'b1;
          end
        end

        // configuration image
        `ADDR_CONFIG: begin
          ppush_d = 1'b1;
          pdata_d = config_word;
        end

        // step-math scratch
        `ADDR_STEP_SCRATCH: begin
          ppush_d = 1'b1;
          pdata_d = step_scratch_q;
        end

        // step-math pseudo: scratch doubled, or root
        `ADDR_STEP_PSEUDO: begin
          ppush_d = 1'b1;
          pdata_d = {step_scratch_q[14:0], 1'b0} | root_scratch_q;
        end

        // square-root scratch
        `ADDR_ROOT_SCRATCH: begin
          ppush_d = 1'b1;
          pdata_d = root_scratch_q;
        end

        // address of the following instruction
        `ADDR_PROG_COUNTER: begin
          ppush_d = 1'b1;
          pdata_d = NEXT_PC_IN;
        end

        // page bits, no return stack change
        `ADDR_PAGE_BITS: begin
          ppush_d = 1'b1;
          pdata_d = {11'h000, page_bits_q};
        end

        // unmapped: no push
        default: begin
          ppush_d = 1'b0;
        end
      endcase
    // writes pop the parameter stack
    end else if (wr) begin
      case (ACCESS_ADDR_IN)
        // index writes in all three modes
        `ADDR_INDEX_DIRECT, `ADDR_INDEX_PUSHPOP, `ADDR_INDEX_LOOP: begin
          ppop_d      = 1'b1;
          index_d     = PSTACK_TOP_IN;
          page_bits_d = cur_page;
          if (in_ret) begin
            // return pops the old top, push of the top refills it
            ret_d      = 1'b1;
            ret_addr_d = top_entry;
          end else if (ACCESS_ADDR_IN == `ADDR_INDEX_PUSHPOP) begin
            rs_push  = 1'b1;
            rs_wdata = top_entry;
          end else if (ACCESS_ADDR_IN == `ADDR_INDEX_LOOP) begin
            stream_d = 1'b1;
          end
        end

        // writable configuration bits
        `ADDR_CONFIG: begin
          ppop_d       = 1'b1;
          disable_d    = PSTACK_TOP_IN[`CFG_DISABLE_SET_BIT];
          boot_d       = PSTACK_TOP_IN[`CFG_BOOT_BIT];
          byte_order_d = PSTACK_TOP_IN[`CFG_BYTE_ORDER_BIT];
        end

        // step-math scratch load
        `ADDR_STEP_SCRATCH: begin
          ppop_d         = 1'b1;
          step_scratch_d = PSTACK_TOP_IN;
        end

        // pseudo write loads the top shifted by a byte
        `ADDR_STEP_PSEUDO: begin
          ppop_d         = 1'b1;
          step_scratch_d = {PSTACK_TOP_IN[15-`PSEUDO_WRITE_SHIFT:0],
                            8'h00};
        end

        // square-root scratch load
        `ADDR_ROOT_SCRATCH: begin
          ppop_d         = 1'b1;
          root_scratch_d = PSTACK_TOP_IN;
        end

        // call, or return to the stack top
        `ADDR_PROG_COUNTER: begin
          ppop_d = 1'b1;
          if (in_ret) begin
            // pushed then popped at once: return goes to the stack top
            ret_d      = 1'b1;
            ret_addr_d = {cur_page, PSTACK_TOP_IN};
          end else begin
            // call: the following address becomes the new top entry
            call_d      = 1'b1;
            call_addr_d = PSTACK_TOP_IN;
            rs_push     = 1'b1;
            rs_wdata    = top_entry;
            index_d     = NEXT_PC_IN;
            page_bits_d = cur_page;
          end
        end

        // page bits load, changes the return page
        `ADDR_PAGE_BITS: begin
          ppop_d      = 1'b1;
          page_bits_d = PSTACK_TOP_IN[4:0];
        end

        // unmapped: no pop
        default: begin
          ppop_d = 1'b0;
        end
      endcase
    end
  end

  // state registers
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      index_q        <= `RST_INDEX;
      page_bits_q    <= `RST_PAGE_BITS;
      disable_q      <= `RST_DISABLE;
      boot_q         <= `RST_BOOT;
      byte_order_q   <= `RST_BYTE_ORDER;
      step_scratch_q <= `RST_STEP_SCRATCH;
      root_scratch_q <= `RST_ROOT_SCRATCH;
    end else begin
      index_q        <= index_d;
      page_bits_q    <= page_bits_d;
      disable_q      <= disable_d;
      boot_q         <= boot_d;
      byte_order_q   <= byte_order_d;
      step_scratch_q <= step_scratch_d;
      root_scratch_q <= root_scratch_d;
    end
  end

  // request pulses and their data, one cycle after the access
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      PSTACK_PUSH_OUT <= 1'b0;
      PSTACK_POP_OUT  <= 1'b0;
      PSTACK_DATA_OUT <= 16'h0000;
      CALL_OUT        <= 1'b0;
      CALL_ADDR_OUT   <= 16'h0000;
      RETURN_OUT      <= 1'b0;
      RETURN_ADDR_OUT <= 21'h000000;
      STREAM_LOAD_OUT <= 1'b0;
    end else begin
      PSTACK_PUSH_OUT <= ppush_d;
      PSTACK_POP_OUT  <= ppop_d;
      PSTACK_DATA_OUT <= pdata_d;
      CALL_OUT        <= call_d;
      CALL_ADDR_OUT   <= call_addr_d;
      RETURN_OUT      <= ret_d;
      RETURN_ADDR_OUT <= ret_addr_d;
      STREAM_LOAD_OUT <= stream_d;
    end
  end

  // entries below the top of the return stack
  return_stack_mem u_rstack (
    .clk     (CLK_IN),
    .reset   (RESET_IN),
    .push    (rs_push),
    .pop     (rs_pop),
    .wdata   (rs_wdata),
    .rdata_q (rs_next)
  );

endmodule
`default_nettype wire

// *** core_regs_map.vh ***
// constants for the core stack register access block: addresses, fields, resets
// assumes inclusion by core_stack_register_access.v and return_stack_mem.v
// Behaviour
// - index holds low 16 of 21-bit top
// - direct read pushes index, return follows
// - direct write pops top into index
// - return write: return first, then push top
// - push/pop read pushes index, pops return
// - push/pop read in return: one pop, return
// - push/pop write moves top onto return stack
// - loop-count read pushes index shifted left once
// - loop-count write loads repeat count
// - loop-count return write: return, push count
// - page bits direct access leaves stack alone
// - index write loads code page, return or not
// - configuration read pushes, write pops in
// - bit15 pending flag, bit14 disable copy
// - bit4 write-only disable, reads zero
// - bit3 drives boot pin, bit2 byte order
// - scratch read pushes, write pops in
// - pseudo read: scratch shl1 or root register
// - pseudo write: top shl8 into scratch
// - root scratch read pushes, write pops in
// - counter read pushes following instruction address
// - counter write calls; in return pushes, pops, returns
`ifndef CORE_REGS_MAP_VH
`define CORE_REGS_MAP_VH

// register addresses on the internal register bus
`define ADDR_INDEX_DIRECT   5'h00
`define ADDR_INDEX_PUSHPOP  5'h01
`define ADDR_INDEX_LOOP     5'h02
`define ADDR_CONFIG         5'h03
`define ADDR_STEP_SCRATCH   5'h04
`define ADDR_STEP_PSEUDO    5'h05
`define ADDR_ROOT_SCRATCH   5'h06
`define ADDR_PROG_COUNTER   5'h07
`define ADDR_PAGE_BITS      5'h0c

// configuration fields
`define CFG_PENDING_BIT     15
`define CFG_DISABLE_BIT     14
`define CFG_DISABLE_SET_BIT 4
`define CFG_BOOT_BIT        3
`define CFG_BYTE_ORDER_BIT  2

// reset values
`define RST_INDEX           16'hffff
`define RST_PAGE_BITS       5'h00
`define RST_DISABLE         1'b1
`define RST_BOOT            1'b1
`define RST_BYTE_ORDER      1'b0
`define RST_STEP_SCRATCH    16'hffff
`define RST_ROOT_SCRATCH    16'h0000

// shifts and return stack geometry
`define PSEUDO_WRITE_SHIFT  8
`define RSTACK_WIDTH        21
`define RSTACK_DEPTH        256
`define RSTACK_PTR_W        8

`endif

// *** return_stack_mem.v ***
// return stack memory below the top entry, with a registered next-entry output
// assumes push and pop come from the register access block, one op per cycle
`timescale 1ns/10ps
`default_nettype none
`include "core_regs_map.vh"

module return_stack_mem (
  // clock and reset
  input  wire                       clk,
  input  wire                       reset,
  // stack operations
  input  wire                       push,
  input  wire                       pop,
  input  wire [`RSTACK_WIDTH-1:0]   wdata,
  // entry just below the top
  output reg  [`RSTACK_WIDTH-1:0]   rdata_q
);

  reg [`RSTACK_WIDTH-1:0] mem [0:`RSTACK_DEPTH-1];
  reg [`RSTACK_PTR_W-1:0] ptr_q;
  wire [`RSTACK_PTR_W-1:0] ptr_m1;
  wire [`RSTACK_PTR_W-1:0] ptr_m2;

  assign ptr_m1 = ptr_q - 8'h01;
  assign ptr_m2 = ptr_q - 8'h02;

  // memory array; pointer wraps, limits are checked elsewhere
  always @(posedge clk) begin
    if (push && !pop) begin
      mem[ptr_q] <= wdata;
    end else if (push && pop) begin
      mem[ptr_m1] <= wdata;           // replace the entry below top
    end
  end

  // pointer and registered read of the entry below top
  always @(posedge clk) begin
    if (reset) begin
      ptr_q   <= 8'h00;
      rdata_q <= 21'h000000;
    end else if (push) begin
      if (!pop) begin
        ptr_q <= ptr_q + 8'h01;
      end
      rdata_q <= wdata;               // bypass the fresh entry
    end else if (pop) begin
      ptr_q   <= ptr_m1;
      rdata_q <= mem[ptr_m2];
    end
  end

endmodule
`default_nettype wire

// *** core_stack_register_access_properties.sv ***
// checker on the ports of the core register access block
// assumes one clock, synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module core_stack_register_access_chk (
  input wire logic        CLK_IN, RESET_IN, ACCESS_VALID_IN, ACCESS_WRITE_IN,
  input wire logic [4:0]  ACCESS_ADDR_IN,
  input wire logic        ACCESS_RETURN_IN, INTERRUPT_PENDING_IN,
  input wire logic [15:0] PSTACK_TOP_IN, NEXT_PC_IN,
  input wire logic        PSTACK_PUSH_OUT, PSTACK_POP_OUT, CALL_OUT, RETURN_OUT,
  input wire logic [15:0] PSTACK_DATA_OUT, CALL_ADDR_OUT, STREAM_COUNT_OUT,
  input wire logic        STREAM_LOAD_OUT, BOOT_SELECT_OUT, BYTE_ORDER_OUT,
  input wire logic        INTERRUPTS_DISABLED_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  // decoded access kinds
  logic hit, rd, wr, rn;
  logic [15:0] top_q;
  assign hit = ACCESS_VALID_IN && (ACCESS_ADDR_IN <= 5'h07 || ACCESS_ADDR_IN == 5'h0c);
  assign rd = hit && !ACCESS_WRITE_IN;
  assign wr = hit && ACCESS_WRITE_IN;
  assign rn = ACCESS_RETURN_IN;
  // stack top of the previous cycle, for the write checks
  always @(posedge CLK_IN) top_q <= PSTACK_TOP_IN;
  property p_rd_push; rd |=> PSTACK_PUSH_OUT && !PSTACK_POP_OUT; endproperty
  a_rd_push: assert property (p_rd_push) else $error("read gave no push");
  property p_wr_pop; wr |=> PSTACK_POP_OUT && !PSTACK_PUSH_OUT; endproperty
  a_wr_pop: assert property (p_wr_pop) else $error("write gave no pop");
  property p_idle; !hit |=> !(PSTACK_PUSH_OUT || PSTACK_POP_OUT || CALL_OUT || RETURN_OUT);
  endproperty
  a_idle: assert property (p_idle) else $error("pulse without access");
  property p_ret_rd; rd && rn && ACCESS_ADDR_IN <= 5'h02 |=> RETURN_OUT && PSTACK_PUSH_OUT;
  endproperty
  a_ret_rd: assert property (p_ret_rd) else $error("return read missed");
  property p_loop_rd; rd && !rn && ACCESS_ADDR_IN == 5'h02
    |=> PSTACK_DATA_OUT == {STREAM_COUNT_OUT[14:0], 1'b0} && $stable(STREAM_COUNT_OUT);
  endproperty
  a_loop_rd: assert property (p_loop_rd) else $error("loop read wrong");
  property p_stream; wr && !rn && ACCESS_ADDR_IN == 5'h02
    |=> STREAM_LOAD_OUT && STREAM_COUNT_OUT == top_q;
  endproperty
  a_stream: assert property (p_stream) else $error("repeat count wrong");
  property p_call; wr && !rn && ACCESS_ADDR_IN == 5'h07
    |=> CALL_OUT && !RETURN_OUT && CALL_ADDR_OUT == top_q;
  endproperty
  a_call: assert property (p_call) else $error("call wrong");
  property p_pc_rd; rd && ACCESS_ADDR_IN == 5'h07 |=> PSTACK_DATA_OUT == $past(NEXT_PC_IN);
  endproperty
  a_pc_rd: assert property (p_pc_rd) else $error("counter read wrong");
  property p_cfg_wr; wr && ACCESS_ADDR_IN == 5'h03
    |=> {INTERRUPTS_DISABLED_OUT, BOOT_SELECT_OUT, BYTE_ORDER_OUT} == top_q[4:2];
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("config write wrong");
  property p_cfg_rd; rd && ACCESS_ADDR_IN == 5'h03
    |=> PSTACK_DATA_OUT == {$past(INTERRUPT_PENDING_IN), INTERRUPTS_DISABLED_OUT, 10'h0,
        BOOT_SELECT_OUT, BYTE_ORDER_OUT, 2'b0};
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config read wrong");
  c_ret_wr: cover property (wr && rn);
  c_pop_rd: cover property (rd && !rn && ACCESS_ADDR_IN == 5'h01);
  c_call: cover property (wr && !rn && ACCESS_ADDR_IN == 5'h07);
endmodule
bind core_stack_register_access core_stack_register_access_chk i_chk (
  .CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .ACCESS_VALID_IN(ACCESS_VALID_IN),
  .ACCESS_WRITE_IN(ACCESS_WRITE_IN), .ACCESS_ADDR_IN(ACCESS_ADDR_IN),
  .ACCESS_RETURN_IN(ACCESS_RETURN_IN), .INTERRUPT_PENDING_IN(INTERRUPT_PENDING_IN),
  .PSTACK_TOP_IN(PSTACK_TOP_IN), .NEXT_PC_IN(NEXT_PC_IN), .PSTACK_PUSH_OUT(PSTACK_PUSH_OUT),
  .PSTACK_POP_OUT(PSTACK_POP_OUT), .CALL_OUT(CALL_OUT), .RETURN_OUT(RETURN_OUT),
  .PSTACK_DATA_OUT(PSTACK_DATA_OUT), .CALL_ADDR_OUT(CALL_ADDR_OUT),
  .STREAM_COUNT_OUT(STREAM_COUNT_OUT), .STREAM_LOAD_OUT(STREAM_LOAD_OUT),
  .BOOT_SELECT_OUT(BOOT_SELECT_OUT), .BYTE_ORDER_OUT(BYTE_ORDER_OUT),
  .INTERRUPTS_DISABLED_OUT(INTERRUPTS_DISABLED_OUT));
`default_nettype wire

// *** param_stack_model.sv ***
// parameter stack of the sequencer, feeding the stack top to the block
// assumes push and pop never come in the same cycle
`timescale 1ns/10ps
`default_nettype none
module param_stack_model (
  input  wire logic        clk_in,
  input  wire logic        put_in,
  input  wire logic [15:0] put_val_in,
  input  wire logic        push_in,
  input  wire logic        pop_in,
  input  wire logic [15:0] data_in,
  output logic      [15:0] top_out
);
  logic [15:0] mem [0:63];
  logic [5:0]  sp = 6'h00;
  // bench loads and block pushes both stack a value; pops drop it
  always @(posedge clk_in) begin
    if (put_in || push_in) begin
      sp <= sp + 6'h01;
      mem[sp + 6'h01] <= put_in ? put_val_in : data_in;
    end else if (pop_in) begin
      sp <= sp - 6'h01;
    end
  end
  assign top_out = mem[sp];
endmodule
`default_nettype wire

// *** core_stack_register_access_tb.sv ***
// self-checking bench for the core register access block
// assumes the parameter stack model supplies the stack top
`timescale 1ns/10ps
`default_nettype none
module core_stack_register_access_tb;
  logic clk_in = 0, reset_in = 1, valid = 0, wr = 0, ret = 0, put = 0, pend = 0, dsel = 0;
  logic [4:0] addr = 0, a;
  logic [3:0] cpg = 0;
  logic [15:0] pval = 0, npc = 0, top, pdata, caddr, scount;
  logic push, pop, call, rtn, sload, boot, byo, dis, w;
  logic [20:0] raddr;
  int mismatches = 0, tests_run = 0;
  // expected state of the block
  logic [15:0] idx = 16'hffff, md = 16'hffff, sr = 16'h0000;
  logic [4:0] pg = 5'h00;
  logic edis = 1, eboot = 1, ebyo = 0;
  logic [20:0] rs[$];
  logic [4:0] lst[11] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
                          5'h0c, 5'h09, 5'h1f};
  initial forever #50 clk_in = ~clk_in;
  core_stack_register_access i_dut (
    .CLK_IN(clk_in), .RESET_IN(reset_in), .ACCESS_VALID_IN(valid), .ACCESS_WRITE_IN(wr),
    .ACCESS_ADDR_IN(addr), .ACCESS_RETURN_IN(ret), .PSTACK_TOP_IN(top),
    .CODE_PAGE_IN(cpg), .DATA_PAGE_SELECT_IN(dsel), .NEXT_PC_IN(npc),
    .INTERRUPT_PENDING_IN(pend), .PSTACK_PUSH_OUT(push), .PSTACK_POP_OUT(pop),
    .PSTACK_DATA_OUT(pdata), .CALL_OUT(call), .CALL_ADDR_OUT(caddr), .RETURN_OUT(rtn),
    .RETURN_ADDR_OUT(raddr), .STREAM_LOAD_OUT(sload), .STREAM_COUNT_OUT(scount),
    .BOOT_SELECT_OUT(boot), .BYTE_ORDER_OUT(byo), .INTERRUPTS_DISABLED_OUT(dis));
  param_stack_model i_pstk (.clk_in(clk_in), .put_in(put), .put_val_in(pval),
    .push_in(push), .pop_in(pop), .data_in(pdata), .top_out(top));
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one access, then the expected outputs and state update
  task automatic acc(input logic w, input logic [4:0] a, input logic r, input logic [15:0] t);
    logic [20:0] top21, ra, nt;
    logic [15:0] d;
    logic ep, eo, er, ec, es;
    if (w) begin
      @(posedge clk_in) put <= 1;
      pval <= t;
      @(posedge clk_in) put <= 0;
    end
    @(posedge clk_in);
    valid <= 1;
    wr <= w;
    addr <= a;
    ret <= r;
    cpg <= 4'($urandom);
    dsel <= 1'($urandom);
    npc <= 16'($urandom);
    pend <= 1'($urandom);
    @(posedge clk_in);
    valid <= 0;
    #1;
    top21 = {pg, idx};
    ra = top21;
    nt = {dsel, cpg, t};
    d = 16'h0;
    ep = !w;
    eo = w;
    er = 0;
    ec = 0;
    es = 0;
    case (a)
      5'h00, 5'h01, 5'h02: if (!w) begin
          d = (a == 5'h02) ? {idx[14:0], 1'b0} : idx;
          er = r;
          if (r || a == 5'h01) {pg, idx} = rs.pop_back();
        end else if (r) begin
          er = 1;
          {pg, idx} = nt;
        end else begin
          if (a == 5'h01) rs.push_back(top21);
          {pg, idx} = nt;
          es = (a == 5'h02);
        end
      5'h03: if (w) {edis, eboot, ebyo} = t[4:2];
        else d = {pend, edis, 10'h0, eboot, ebyo, 2'b0};
      5'h04: if (w) md = t; else d = md;
      5'h05: if (w) md = t << 8; else d = (md << 1) | sr;
      5'h06: if (w) sr = t; else d = sr;
      5'h07: if (!w) d = npc;
        else if (r) begin
          er = 1;
          ra = nt;
        end else begin
          ec = 1;
          rs.push_back(top21);
          {pg, idx} = {dsel, cpg, npc};
        end
      5'h0c: if (w) pg = t[4:0]; else d = {11'h0, pg};
      default: begin ep = 0; eo = 0; end
    endcase
    chk(21'(push), 21'(ep));
    chk(21'(pop), 21'(eo));
    chk(21'(rtn), 21'(er));
    chk(21'(call), 21'(ec));
    chk(21'(sload), 21'(es));
    if (ep) chk(21'(pdata), 21'(d));
    if (er) chk(raddr, ra);
    if (ec) chk(21'(caddr), 21'(t));
    chk(21'(scount), 21'(idx));
    chk(21'({boot, byo, dis}), 21'({eboot, ebyo, edis}));
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watchdog against a hung sequence
  initial begin
    repeat (5000) @(posedge clk_in);
    mismatches++;
    test_done;
  end
  // corner cases, then random traffic
  initial begin
    void'($urandom(27540));
    repeat (8) @(posedge clk_in);
    reset_in <= 0;
    acc(0, 5'h00, 0, 0);
    acc(0, 5'h03, 0, 0);
    acc(0, 5'h04, 0, 0);
    acc(0, 5'h0c, 0, 0);
    acc(1, 5'h03, 0, 16'h0010);
    acc(0, 5'h03, 0, 0);
    acc(1, 5'h03, 0, 16'hffe8);
    acc(1, 5'h03, 0, 16'h0004);
    repeat (4) acc(1, 5'h01, 0, 16'($urandom));
    acc(0, 5'h00, 1, 0);
    acc(0, 5'h01, 1, 0);
    acc(0, 5'h02, 1, 0);
    acc(0, 5'h01, 0, 0);
    acc(1, 5'h00, 1, 16'h1234);
    acc(1, 5'h01, 1, 16'h4321);
    acc(1, 5'h02, 1, 16'h0005);
    acc(1, 5'h07, 0, 16'h8000);
    acc(1, 5'h07, 1, 16'h0abc);
    acc(0, 5'h07, 0, 0);
    acc(1, 5'h05, 0, 16'h00a5);
    acc(1, 5'h06, 0, 16'h8001);
    acc(0, 5'h05, 0, 0);
    acc(1, 5'h02, 0, 16'h0007);
    acc(0, 5'h02, 0, 0);
    acc(1, 5'h0c, 0, 16'h001f);
    acc(0, 5'h0c, 0, 0);
    acc(1, 5'h00, 0, 16'h5a5a);
    acc(1, 5'h09, 0, 16'h7777);
    acc(0, 5'h1f, 0, 0);
    for (int i = 0; i < 80; i++) begin
      a = lst[$urandom % 11];
      w = (a == 5'h01) ? 1'b1 : 1'($urandom);
      acc(w, a, 0, 16'($urandom));
    end
    test_done;
  end
endmodule
`default_nettype wire
